// *** core/cal_loader.sv ***
// config autoload sequencer: loads identity and link setup bytes from parallel flash, then 2-wire eeprom
// assumes host-bus reset, flash data and serial data arrive asynchronously; outputs feed config header
`timescale 1ns/1ps
`include "cal_defines.svh"

// How it works
// [R1] Leaving host-bus reset starts flash detection and the configuration load.
// [R2] First flash read begins 660 ns after host-bus reset release.
// [R3] Read 7FFFF then 7FFFE; they must hold AA then 55.
// [R4] On a good start, keep counting down to read sixteen bytes total.
// [R5] Commit the twelve field bytes only when 7FFFC holds 55.
// [R6] Byte at 7FFFD equal to AA selects 120 ns reads, else 240 ns.
// [R7] Bytes 7FFFB..7FFF0 fill device ID, class, subsystem IDs, PHY word.
// [R8] The flash phase completes within 9600 ns.
// [R9] Host-bus accesses get Target Retry while either load runs.
// [R10] A valid eeprom image overrides values loaded from flash.
// [R11] Eeprom sequence starts 26 us after the flash phase ends.
// [R12] Eeprom addressing covers parts of up to 256 bytes.
// [R13] Transfer opens with data falling while serial clock is high.
// [R14] Control byte is 1010, select 000, direction write.
// [R15] Word address 00 follows the acknowledged control byte; eeprom acknowledges it.
// [R16] Eeprom returns sequential bytes with acknowledges; transfer ends with STOP.
// [R17] Direction bit is 0 for write, 1 for read.
// [R18] Serial clock period is 19.26 us; the quarter count rounds down to 481 cycles, so the code gives 19.24 us.
// [R19] Eeprom phase spans 2.66 ms from its start; a full image read at the default serial clock runs longer.
// [R20] Bytes 0,1 present AA,55; bytes 2,3 signature AA,55; 4..15 fields.
// [R21] Flash address bus is 19 bits, data bus 8 bits.
// [R22] Read strobe and memory select go low to read flash.
// [R23] Repeated start, read control byte, last byte not acknowledged before STOP.
// [R24] Failed checks leave that source's values untouched and end its sequence; a bad eeprom signature byte does not end the reads.
module cal_loader import cal_pkg::*; #(
  parameter int          P_PROM_CYC         = `CAL_T_PROM_CYC,
  parameter int          P_QCYC             = `CAL_T_SCL_QCYC,
  parameter logic [15:0] P_DEF_DEVICE_ID_HI = 16'h0000, // arbitrary
  parameter logic [15:0] P_DEF_CLASS_HI     = 16'h0000,
  parameter logic [15:0] P_DEF_SSVID        = 16'h0000, // arbitrary
  parameter logic [15:0] P_DEF_SSID_HI      = 16'h0000, // arbitrary
  parameter logic [31:0] P_DEF_PHY_CONFIG   = 32'h0000_0000
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic        i_pci_rst_n,
  input  wire logic [7:0]  i_flash_data_bus,
  input  wire logic        i_prom_serial_data,
  output logic [18:0]      o_flash_addr_bus,
  output logic             o_flash_read_strobe_n,
  output logic             o_flash_write_strobe_n,
  output logic             o_mem_select_n,
  output logic             o_prom_serial_clock,
  output logic             o_prom_serial_data_out,
  output logic             o_prom_serial_data_oe,
  output logic             o_target_retry,
  output logic             o_load_done,
  output logic             o_flash_loaded,
  output logic             o_prom_loaded,
  output logic             o_flash_fast,
  output logic [15:0]      o_device_id_hi,
  output logic [15:0]      o_class_code_hi,
  output logic [15:0]      o_subsys_vendor_id,
  output logic [15:0]      o_subsys_id_hi,
  output logic [31:0]      o_phy_config
);

  if (P_PROM_CYC < 1 || P_PROM_CYC > 524287) begin : g_chk_prom
    $error("cal_loader: P_PROM_CYC out of range");
  end

  // counters load one less than the span: the zero cycle counts too
  localparam logic [18:0] LEAD_LOAD  = 19'(`CAL_T_LEAD_CYC - 1);
  localparam logic [18:0] FLASH_LAST = 19'(`CAL_T_FLASH_CYC - 1);
  localparam logic [18:0] GAP_LOAD   = 19'(`CAL_T_GAP_CYC - 1);
  localparam logic [18:0] PROM_LAST  = 19'(P_PROM_CYC - 1);

  typedef struct packed {
    cal_st_t          st;
    logic             rst_s1;
    logic             rst_s2;
    logic             rst_d;
    logic [7:0]       dat_s1;
    logic [7:0]       dat_s2;
    logic [18:0]      cnt;
    logic [18:0]      cyc;
    logic [4:0]       idx;
    logic [4:0]       step;
    logic             pend;
    logic             pass;
    logic [11:0][7:0] stage;
    logic             go;
    cal_sym_t         kind;
    logic [8:0]       tx;
    logic [18:0]      addr;
    logic             rd_n;
    logic             wr_n;
    logic             cs_n;
    logic             retry;
    logic             done;
    logic             fl_ok;
    logic             pr_ok;
    logic             fast;
    logic [15:0]      devid;
    logic [15:0]      ccode;
    logic [15:0]      ssvid;
    logic [15:0]      ssid;
    logic [31:0]      phy;
  } cal_ld_t;

  cal_ld_t    r_r, r_nxt;
  logic       sc_busy;
  logic       sc_done;
  logic [8:0] sc_rx;

  // read wait per byte; sync stages add latency before the bus value is seen
  function automatic logic [18:0] read_wait(logic fast);
    return fast ? 19'(`CAL_T_FAST_CYC - 1 + `CAL_SYNC_CYC) : 19'(`CAL_T_SLOW_CYC - 1 + `CAL_SYNC_CYC); // [R6]
  endfunction : read_wait

  // staged field bytes into the configuration outputs
  function automatic cal_ld_t commit(cal_ld_t s);
    cal_ld_t o;
    o = s;
    o.devid = {s.stage[1], s.stage[0]}; // [R7]
    o.ccode = {s.stage[3], s.stage[2]};
    o.ssvid = {s.stage[5], s.stage[4]};
    o.ssid  = {s.stage[7], s.stage[6]};
    o.phy   = {s.stage[11], s.stage[10], s.stage[9], s.stage[8]};
    return o;
  endfunction : commit

  always_comb begin
    logic       ok;
    logic       fin;
    logic [7:0] rbyte;
    logic [4:0] k;
    ok    = 1'b1;
    fin   = 1'b0;
    rbyte = sc_rx[8:1];
    k     = 5'(r_r.step - `CAL_PS_RD_FIRST);
    r_nxt = r_r;
    r_nxt.go     = 1'b0;
    // host-bus reset and flash data are asynchronous pins
    r_nxt.rst_s1 = i_pci_rst_n;
    r_nxt.rst_s2 = r_r.rst_s1;
    r_nxt.rst_d  = r_r.rst_s2;
    r_nxt.dat_s1 = i_flash_data_bus;
    r_nxt.dat_s2 = r_r.dat_s1;
    if (!r_r.rst_s2) begin
      // host-bus reset in force: restart from scratch, loaded values kept
      r_nxt.st    = CAL_ST_RESET;
      r_nxt.rd_n  = 1'b1;
      r_nxt.cs_n  = 1'b1;
      r_nxt.retry = 1'b1;
      r_nxt.done  = 1'b0;
      r_nxt.pend  = 1'b0;
    end else begin
      case (r_r.st)
        CAL_ST_RESET: begin
          if (!r_r.rst_d) begin
            r_nxt.st  = CAL_ST_LEAD; // [R1]
            r_nxt.cnt = LEAD_LOAD;
          end
        end
        CAL_ST_LEAD: begin
          if (r_r.cnt != 19'd0) begin
            r_nxt.cnt = r_r.cnt - 19'd1;
          end else begin
            r_nxt.st    = CAL_ST_FLASH; // [R2]
            r_nxt.addr  = `CAL_FLASH_TOP; // [R21]
            r_nxt.rd_n  = 1'b0; // [R22]
            r_nxt.cs_n  = 1'b0;
            r_nxt.idx   = 5'd0;
            r_nxt.fast  = 1'b0;
            r_nxt.cyc   = 19'd0;
            r_nxt.fl_ok = 1'b0;
            r_nxt.cnt   = read_wait(1'b0);
          end
        end
        CAL_ST_FLASH: begin
          r_nxt.cyc = r_r.cyc + 19'd1;
          if (!r_r.rd_n) begin
            if (r_r.cnt != 19'd0) begin
              r_nxt.cnt = r_r.cnt - 19'd1;
            end else begin
              case (r_r.idx)
                5'd0: ok = (r_r.dat_s2 == `CAL_SIG_A); // [R3]
                5'd1: ok = (r_r.dat_s2 == `CAL_SIG_B); // [R3]
                5'd2: r_nxt.fast = (r_r.dat_s2 == `CAL_FAST_CODE); // [R6]
                5'd3: ok = (r_r.dat_s2 == `CAL_SIG_B); // [R5]
                default: r_nxt.stage[4'(r_r.idx - 5'(`CAL_FIELD_FIRST))] = r_r.dat_s2; // [R7]
              endcase
              if (!ok) begin
                fin = 1'b1; // [R24]
              end else if (r_r.idx == 5'(`CAL_IMG_BYTES - 1)) begin
                r_nxt       = commit(r_nxt); // [R5]
                r_nxt.fl_ok = 1'b1;
                fin         = 1'b1;
              end else begin
                r_nxt.idx  = r_r.idx + 5'd1; // [R4]
                r_nxt.addr = r_r.addr - 19'd1;
                r_nxt.cnt  = read_wait(r_nxt.fast);
              end
              if (fin) begin
                r_nxt.rd_n = 1'b1;
                r_nxt.cs_n = 1'b1;
              end
            end
          end else if (r_r.cyc >= FLASH_LAST) begin
            // reads take far less; the phase is padded to its fixed span
            r_nxt.st  = CAL_ST_GAP; // [R8]
            r_nxt.cnt = GAP_LOAD;
          end
        end
        CAL_ST_GAP: begin
          if (r_r.cnt != 19'd0) begin
            r_nxt.cnt = r_r.cnt - 19'd1;
          end else begin
            r_nxt.st    = CAL_ST_PROM; // [R11]
            r_nxt.step  = `CAL_PS_START;
            r_nxt.pend  = 1'b0;
            r_nxt.pass  = 1'b1;
            r_nxt.cyc   = 19'd0;
            r_nxt.pr_ok = 1'b0;
          end
        end
        CAL_ST_PROM: begin
          r_nxt.cyc = r_r.cyc + 19'd1;
          if (!r_r.pend && !sc_busy) begin
            r_nxt.go   = 1'b1;
            r_nxt.pend = 1'b1;
            r_nxt.kind = CAL_SYM_BYTE;
            if (r_r.step == `CAL_PS_START || r_r.step == `CAL_PS_RESTART) begin
              r_nxt.kind = CAL_SYM_START; // [R13] [R23]
            end else if (r_r.step == `CAL_PS_STOP) begin
              r_nxt.kind = CAL_SYM_STOP; // [R16]
            end else if (r_r.step == `CAL_PS_CTRL_WR) begin
              r_nxt.tx = {`CAL_PROM_CTRL_WR, 1'b1}; // [R14] [R17]
            end else if (r_r.step == `CAL_PS_ADDR) begin
              r_nxt.tx = {`CAL_PROM_START_ADDR, 1'b1}; // [R15] [R12]
            end else if (r_r.step == `CAL_PS_CTRL_RD) begin
              r_nxt.tx = {`CAL_PROM_CTRL_RD, 1'b1}; // [R17] [R23]
            end else begin
              // release data, then acknowledge all but the final byte
              r_nxt.tx = {8'hff, r_r.step == `CAL_PS_RD_LAST}; // [R16] [R23]
            end
          end else if (r_r.pend && sc_done) begin
            r_nxt.pend = 1'b0;
            r_nxt.step = r_r.step + 5'd1;
            if (r_r.step == `CAL_PS_CTRL_WR || r_r.step == `CAL_PS_ADDR || r_r.step == `CAL_PS_CTRL_RD) begin
              if (sc_rx[0]) begin
                r_nxt.pass = 1'b0; // [R24]
                r_nxt.step = `CAL_PS_STOP; // [R15]
              end
            end else if (r_r.step >= `CAL_PS_RD_FIRST && r_r.step <= `CAL_PS_RD_LAST) begin
              case (k)
                5'd0, 5'd2: ok = (rbyte == `CAL_SIG_A); // [R20]
                5'd1, 5'd3: ok = (rbyte == `CAL_SIG_B); // [R20]
                default: r_nxt.stage[4'(k - 5'(`CAL_FIELD_FIRST))] = rbyte; // [R20]
              endcase
              if (!ok) begin
                r_nxt.pass = 1'b0;
              end
            end else if (r_r.step == `CAL_PS_STOP) begin
              r_nxt.st = CAL_ST_HOLD;
              if (r_r.pass) begin
                r_nxt       = commit(r_nxt); // [R10]
                r_nxt.pr_ok = 1'b1;
              end
            end
          end
        end
        // a long transfer overruns the minimum span; done then follows at once
        CAL_ST_HOLD: begin
          if (r_r.cyc >= PROM_LAST) begin
            r_nxt.st    = CAL_ST_DONE; // [R19]
            r_nxt.retry = 1'b0;
            r_nxt.done  = 1'b1;
          end else begin
            r_nxt.cyc = r_r.cyc + 19'd1;
          end
        end
        CAL_ST_DONE: begin
          r_nxt.retry = 1'b0;
        end
        default: begin
          r_nxt.st = CAL_ST_RESET;
        end
      endcase
    end
  end

  // only the system reset restores default fields; host-bus reset keeps them
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      r_r        <= '0;
      r_r.rd_n   <= 1'b1;
      r_r.wr_n   <= 1'b1;
      r_r.cs_n   <= 1'b1;
      r_r.retry  <= 1'b1; // [R9]
      r_r.devid  <= P_DEF_DEVICE_ID_HI;
      r_r.ccode  <= P_DEF_CLASS_HI;
      r_r.ssvid  <= P_DEF_SSVID;
      r_r.ssid   <= P_DEF_SSID_HI;
      r_r.phy    <= P_DEF_PHY_CONFIG;
      r_r.addr   <= `CAL_FLASH_TOP;
    end else begin
      r_r <= r_nxt;
    end
  end

  // engine sees only the system reset, so a symbol in flight ends on its own
  cal_serial #(
    .P_QCYC (P_QCYC)
  ) u_serial (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_go      (r_r.go),
    .i_kind    (r_r.kind),
    .i_tx      (r_r.tx),
    .i_sda     (i_prom_serial_data),
    .o_busy    (sc_busy),
    .o_done    (sc_done),
    .o_rx      (sc_rx),
    .o_scl     (o_prom_serial_clock),
    .o_sda_out (o_prom_serial_data_out),
    .o_sda_oe  (o_prom_serial_data_oe)
  );

  assign o_flash_addr_bus       = r_r.addr;
  assign o_flash_read_strobe_n  = r_r.rd_n;
  assign o_flash_write_strobe_n = r_r.wr_n;
  assign o_mem_select_n         = r_r.cs_n;
  assign o_target_retry         = r_r.retry; // [R9]
  assign o_load_done            = r_r.done;
  assign o_flash_loaded         = r_r.fl_ok;
  assign o_prom_loaded          = r_r.pr_ok;
  assign o_flash_fast           = r_r.fast;
  assign o_device_id_hi         = r_r.devid;
  assign o_class_code_hi        = r_r.ccode;
  assign o_subsys_vendor_id     = r_r.ssvid;
  assign o_subsys_id_hi         = r_r.ssid;
  assign o_phy_config           = r_r.phy;

endmodule : cal_loader

// *** core/cal_defines.svh ***
// config autoload sequencer: offsets, signature values, field positions and timing counts
// assumes a 100 MHz system clock; every count except CAL_SYNC_CYC derives from a time in ns
`ifndef CAL_DEFINES_SVH
`define CAL_DEFINES_SVH

`define CAL_CLK_NS          10
// round a least time up, a longest time down
`define CAL_CEIL_CYC(ns)    (((ns) + `CAL_CLK_NS - 1) / `CAL_CLK_NS)
`define CAL_FLOOR_CYC(ns)   ((ns) / `CAL_CLK_NS)

`define CAL_T_LEAD_NS       660
`define CAL_T_LEAD_CYC      `CAL_CEIL_CYC(`CAL_T_LEAD_NS)
`define CAL_T_FLASH_NS      9600
`define CAL_T_FLASH_CYC     `CAL_FLOOR_CYC(`CAL_T_FLASH_NS)
`define CAL_T_FAST_NS       120
`define CAL_T_FAST_CYC      `CAL_CEIL_CYC(`CAL_T_FAST_NS)
`define CAL_T_SLOW_NS       240
`define CAL_T_SLOW_CYC      `CAL_CEIL_CYC(`CAL_T_SLOW_NS)
`define CAL_T_GAP_NS        26000
`define CAL_T_GAP_CYC       `CAL_CEIL_CYC(`CAL_T_GAP_NS)
`define CAL_T_SCL_NS        19260
`define CAL_T_SCL_QCYC      (`CAL_T_SCL_NS / (4 * `CAL_CLK_NS))
`define CAL_T_PROM_NS       2660000
`define CAL_T_PROM_CYC      `CAL_CEIL_CYC(`CAL_T_PROM_NS)
`define CAL_SYNC_CYC        2

`define CAL_FLASH_TOP       19'h7ffff
`define CAL_SIG_A           8'haa
`define CAL_SIG_B           8'h55
`define CAL_FAST_CODE       8'haa
`define CAL_IMG_BYTES       16
`define CAL_FIELD_BYTES     12
`define CAL_FIELD_FIRST     4
`define CAL_PROM_CTRL_WR    8'ha0
`define CAL_PROM_CTRL_RD    8'ha1
`define CAL_PROM_START_ADDR 8'h00

// eeprom command steps
`define CAL_PS_START        5'd0
`define CAL_PS_CTRL_WR      5'd1
`define CAL_PS_ADDR         5'd2
`define CAL_PS_RESTART      5'd3
`define CAL_PS_CTRL_RD      5'd4
`define CAL_PS_RD_FIRST     5'd5
`define CAL_PS_RD_LAST      5'd20
`define CAL_PS_STOP         5'd21
`define CAL_PS_END          5'd22

`endif

// *** core/cal_pkg.sv ***
// config autoload sequencer: shared types
// assumes cal_defines.svh is on the include path
package cal_pkg;
`include "cal_defines.svh"

  typedef enum logic [2:0] {
    CAL_ST_RESET = 3'b000,
    CAL_ST_LEAD  = 3'b001,
    CAL_ST_FLASH = 3'b011,
    CAL_ST_GAP   = 3'b010,
    CAL_ST_PROM  = 3'b110,
    CAL_ST_HOLD  = 3'b111,
    CAL_ST_DONE  = 3'b101
  } cal_st_t;

  typedef enum logic [1:0] {
    CAL_SYM_START = 2'b00,
    CAL_SYM_STOP  = 2'b01,
    CAL_SYM_BYTE  = 2'b11
  } cal_sym_t;

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic [9:0] div;
    logic [1:0] q;
    logic [3:0] nbit;
    logic       busy;
    cal_sym_t   kind;
    logic [8:0] tx;
    logic [8:0] rx;
    logic       done;
    logic       scl;
    logic       oe;
    logic       low;
  } cal_sc_t;

endpackage : cal_pkg

// *** core/cal_serial.sv ***
// config autoload sequencer: two-wire bit engine for start, stop and 9-bit byte symbols
// assumes one command at a time, issued only while o_busy is low
`timescale 1ns/1ps
`include "cal_defines.svh"
module cal_serial import cal_pkg::*; #(
  parameter int P_QCYC = `CAL_T_SCL_QCYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  input  wire logic       i_go,
  input  wire cal_sym_t   i_kind,
  input  wire logic [8:0] i_tx,
  input  wire logic       i_sda,
  output logic            o_busy,
  output logic            o_done,
  output logic [8:0]      o_rx,
  output logic            o_scl,
  output logic            o_sda_out,
  output logic            o_sda_oe
);

  if (P_QCYC < 2 || P_QCYC > 1023) begin : g_chk
    $error("cal_serial: P_QCYC out of range");
  end

  localparam logic [9:0] QRELOAD = 10'(P_QCYC - 1);

  cal_sc_t r_r, r_nxt;

  // action taken on entry to quarter s.q of the current symbol
  function automatic cal_sc_t enter_q(cal_sc_t s);
    cal_sc_t o;
    o = s;
    case (s.kind)
      CAL_SYM_START: begin
        case (s.q)
          2'd0: begin o.scl = 1'b0; o.oe = 1'b0; end
          2'd1: o.scl = 1'b1;
          2'd2: o.oe = 1'b1; // [R13]
          default: o.scl = 1'b0;
        endcase
      end
      CAL_SYM_STOP: begin
        case (s.q)
          2'd0: begin o.scl = 1'b0; o.oe = 1'b1; end
          2'd1: o.scl = 1'b1;
          2'd2: o.oe = 1'b0; // [R16]
          default: o.scl = 1'b1;
        endcase
      end
      default: begin
        case (s.q)
          2'd0: begin o.scl = 1'b0; o.oe = ~s.tx[8]; end
          2'd1: o.scl = 1'b1;
          2'd2: o.rx = {s.rx[7:0], s.s2};
          default: o.scl = 1'b0;
        endcase
      end
    endcase
    return o;
  endfunction : enter_q

  always_comb begin
    r_nxt = r_r;
    r_nxt.done = 1'b0;
    r_nxt.s1 = i_sda;
    r_nxt.s2 = r_r.s1;
    if (!r_r.busy) begin
      if (i_go) begin
        r_nxt.busy = 1'b1;
        r_nxt.kind = i_kind;
        r_nxt.tx   = i_tx;
        r_nxt.nbit = (i_kind == CAL_SYM_BYTE) ? 4'd8 : 4'd0;
        r_nxt.q    = 2'd0;
        r_nxt.div  = QRELOAD;
        r_nxt      = enter_q(r_nxt);
      end
    end else if (r_r.div != 10'd0) begin
      r_nxt.div = r_r.div - 10'd1;
    end else begin
      r_nxt.div = QRELOAD; // [R18]
      if (r_r.q == 2'd3) begin
        if (r_r.nbit == 4'd0) begin
          r_nxt.busy = 1'b0;
          r_nxt.done = 1'b1;
        end else begin
          r_nxt.nbit = r_r.nbit - 4'd1;
          r_nxt.tx   = {r_r.tx[7:0], 1'b1};
          r_nxt.q    = 2'd0;
          r_nxt      = enter_q(r_nxt);
        end
      end else begin
        r_nxt.q = r_r.q + 2'd1;
        r_nxt   = enter_q(r_nxt);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      r_r     <= '0;
      r_r.scl <= 1'b1;
      r_r.s1  <= 1'b1;
      r_r.s2  <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign o_busy    = r_r.busy;
  assign o_done    = r_r.done;
  assign o_rx      = r_r.rx;
  assign o_scl     = r_r.scl;
  assign o_sda_out = r_r.low;
  assign o_sda_oe  = r_r.oe;

endmodule : cal_serial

// *** testbench/cal_loader_sva.sv ***
// checker: pin relations and timing of the config loader, seen at its ports
// assumes 100 MHz clock; quarter count handed down by the bind
`timescale 1ns/1ps
module cal_loader_sva #(
  parameter int P_QCYC = 481
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic        i_pci_rst_n,
  input  wire logic [18:0] o_flash_addr_bus,
  input  wire logic        o_flash_read_strobe_n,
  input  wire logic        o_flash_write_strobe_n,
  input  wire logic        o_mem_select_n,
  input  wire logic        o_prom_serial_clock,
  input  wire logic        o_prom_serial_data_out,
  input  wire logic        o_prom_serial_data_oe,
  input  wire logic        o_target_retry,
  input  wire logic        o_load_done,
  input  wire logic        o_flash_loaded,
  input  wire logic        o_prom_loaded
);
  int   rel_cnt_r;
  int   rise_cnt_r;
  logic seen_scl_r;
  // counts from host-bus release; abort clears it
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !i_pci_rst_n) begin
      rel_cnt_r  <= 0;
      seen_scl_r <= 1'b0;
    end else begin
      rel_cnt_r  <= (rel_cnt_r < 100000) ? rel_cnt_r + 1 : rel_cnt_r;
      seen_scl_r <= seen_scl_r | !o_prom_serial_clock;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    rise_cnt_r <= $rose(o_prom_serial_clock) ? 0 : rise_cnt_r + 1;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  a_first_read: assert property ($fell(o_flash_read_strobe_n) |-> rel_cnt_r inside {[66:72]})
    else $error("first flash read off time");
  a_flash_span: assert property ($rose(o_flash_read_strobe_n) |-> rel_cnt_r <= 1035)
    else $error("flash reads overran");
  a_gap_start: assert property ($fell(o_prom_serial_clock) && !seen_scl_r |-> rel_cnt_r inside {[3620:3680]})
    else $error("eeprom start gap wrong");
  a_write_idle: assert property (o_flash_write_strobe_n)
    else $error("flash write strobe active");
  a_select_pair: assert property (o_mem_select_n == o_flash_read_strobe_n)
    else $error("select not with read strobe");
  a_retry_done: assert property (o_target_retry != o_load_done)
    else $error("retry and done disagree");
  a_addr_down: assert property ($changed(o_flash_addr_bus) && !o_flash_read_strobe_n &&
    !$past(o_flash_read_strobe_n) |-> o_flash_addr_bus == $past(o_flash_addr_bus) - 19'h00001)
    else $error("flash address not stepping down");
  a_sclk_period: assert property ($rose(o_prom_serial_clock) && seen_scl_r |-> rise_cnt_r >= 4 * P_QCYC - 1)
    else $error("serial clock period short");
  a_od_zero: assert property (!o_prom_serial_data_out)
    else $error("data line driven high");
  a_stop_idle: assert property ($rose(o_load_done) |-> o_prom_serial_clock && !o_prom_serial_data_oe)
    else $error("serial bus busy at done");
  c_flash: cover property ($rose(o_flash_loaded));
  c_prom: cover property ($rose(o_prom_loaded));
  c_done: cover property ($rose(o_load_done));
endmodule : cal_loader_sva

bind cal_loader cal_loader_sva #(.P_QCYC(P_QCYC)) u_sva (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_pci_rst_n(i_pci_rst_n),
  .o_flash_addr_bus(o_flash_addr_bus), .o_flash_read_strobe_n(o_flash_read_strobe_n),
  .o_flash_write_strobe_n(o_flash_write_strobe_n), .o_mem_select_n(o_mem_select_n),
  .o_prom_serial_clock(o_prom_serial_clock), .o_prom_serial_data_out(o_prom_serial_data_out),
  .o_prom_serial_data_oe(o_prom_serial_data_oe), .o_target_retry(o_target_retry),
  .o_load_done(o_load_done), .o_flash_loaded(o_flash_loaded), .o_prom_loaded(o_prom_loaded)
);

// *** testbench/cal_mem_model.sv ***
// partner: 16-byte top of parallel flash and a 2-wire eeprom with sequential reads
// assumes the bench resolves the data line from both pull-down enables with a pull-up
`timescale 1ns/1ps
module cal_mem_model (
  input  wire logic [18:0] i_addr,
  input  wire logic        i_rd_n,
  input  wire logic        i_sel_n,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic [7:0]       o_data,
  output logic             o_sda_pull
);
  logic [7:0]  fmem [16];
  logic [7:0]  pmem [256];
  logic [7:0]  sh, obyte, ptr;
  logic [15:0] ctrl_log;
  logic        present, act, rd, ok, mack, dir, cb;
  int          bitn, starts;
  // deselected flash shows the inverted byte, never a stale copy
  assign o_data = (!i_rd_n && !i_sel_n) ? fmem[~i_addr[3:0]] : ~fmem[~i_addr[3:0]];
  initial begin
    foreach (fmem[i]) fmem[i] = 8'h00;
    {present, act, rd, ok, mack, dir, cb, o_sda_pull} = 8'h00;
    {sh, obyte, ptr, ctrl_log} = 40'h0;
    bitn = 0;
    starts = 0;
  end
  always @(negedge i_sda) if (i_scl === 1'b1) begin
    {act, cb, rd} = 3'b110;
    bitn = -1;
    starts++;
  end
  always @(posedge i_sda) if (i_scl === 1'b1) act = 1'b0;
  always @(posedge i_scl) if (act) begin
    if (!rd && bitn < 8) sh = {sh[6:0], i_sda};
    if (rd && bitn == 8) mack = !i_sda;
  end
  always @(negedge i_scl) if (act) begin
    bitn = bitn + 1;
    if (bitn == 8 && !rd) begin
      if (cb) begin
        ok = present && sh[7:1] == 7'h50;
        dir = sh[0];
        mack = 1'b1;
        ctrl_log = {ctrl_log[7:0], sh};
      end else ptr = sh;
      cb = 1'b0;
      o_sda_pull = ok;
    end else if (bitn == 8) o_sda_pull = 1'b0;
    else if (bitn == 9) begin
      bitn = 0;
      rd = dir;
      o_sda_pull = 1'b0;
      if (rd && mack) begin
        obyte = pmem[ptr];
        ptr = ptr + 8'h01;
      end else if (rd) act = 1'b0;
    end
    if (rd && act && bitn < 8) o_sda_pull = !obyte[7 - bitn];
  end
endmodule : cal_mem_model

// *** testbench/test_cal_loader.sv ***
// testbench: whole load runs over flash and eeprom images, fields checked at the end
// assumes cal_loader with a short eeprom phase and a 160 ns serial bit
`timescale 1ns/1ps
module test_cal_loader;
  logic        i_clk_sys = 1'b0;
  logic        i_srst = 1'b1;
  logic        i_pci_rst_n = 1'b0;
  logic [7:0]  fdata;
  logic [18:0] addr;
  logic        pull, sda, rd_n, wr_n, sel_n, scl, sda_o, sda_oe, retry, done, floaded, ploaded, fast;
  logic [15:0] dev, cls, ssv, ssid;
  logic [31:0] phy;
  int          failures = 0;
  int          checks = 0;
  int          cyc = 0;
  assign sda = !(sda_oe === 1'b1 || pull);
  cal_loader #(.P_PROM_CYC(200), .P_QCYC(4)) uut (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_pci_rst_n(i_pci_rst_n),
    .i_flash_data_bus(fdata), .i_prom_serial_data(sda), .o_flash_addr_bus(addr),
    .o_flash_read_strobe_n(rd_n), .o_flash_write_strobe_n(wr_n), .o_mem_select_n(sel_n),
    .o_prom_serial_clock(scl), .o_prom_serial_data_out(sda_o), .o_prom_serial_data_oe(sda_oe),
    .o_target_retry(retry), .o_load_done(done), .o_flash_loaded(floaded), .o_prom_loaded(ploaded),
    .o_flash_fast(fast), .o_device_id_hi(dev), .o_class_code_hi(cls), .o_subsys_vendor_id(ssv),
    .o_subsys_id_hi(ssid), .o_phy_config(phy));
  cal_mem_model mdl (.i_addr(addr), .i_rd_n(rd_n), .i_sel_n(sel_n), .i_scl(scl), .i_sda(sda),
    .o_data(fdata), .o_sda_pull(pull));
  always #5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] fb(input logic [7:0] b, input int k);
    return (b == 8'h00) ? 8'h00 : b + 8'(k);
  endfunction : fb
  task automatic step();
    @(posedge i_clk_sys);
    #1;
  endtask : step
  task automatic run(input logic [7:0] f0, input logic [7:0] f2, input logic [7:0] f3,
                     input logic pres, input logic [7:0] p3);
    int         n;
    logic       fl, pr;
    logic [7:0] b;
    i_srst = 1'b1;
    i_pci_rst_n = 1'b0;
    repeat (16) step();
    for (int i = 0; i < 16; i++) begin
      mdl.fmem[i] = (i == 0) ? f0 : (i == 1) ? 8'h55 : (i == 2) ? f2 : (i == 3) ? f3 : 8'h10 + 8'(i);
      mdl.pmem[i] = (i == 0 || i == 2) ? 8'haa : (i == 1) ? 8'h55 : (i == 3) ? p3 : 8'h80 + 8'(i);
    end
    mdl.present = pres;
    mdl.ctrl_log = 16'h0000;
    mdl.starts = 0;
    i_srst = 1'b0;
    repeat (4) step();
    check({retry, done, dev}, {2'b10, 16'h0000});
    i_pci_rst_n = 1'b1;
    fl = (f0 == 8'haa) && (f3 == 8'h55);
    pr = pres && (p3 == 8'h55);
    b = pr ? 8'h80 : fl ? 8'h10 : 8'h00;
    if (fl) begin
      n = 0;
      while (addr !== 19'h7fff8 && n < 2000) begin step(); n++; end
      n = 0;
      while (addr === 19'h7fff8 && n < 100) begin step(); n++; end
      check(32'(n), (f2 == 8'haa) ? 32'd14 : 32'd26);
      check(fast, f2 == 8'haa);
    end
    check(retry, 1'b1);
    n = 0;
    while (done !== 1'b1 && n < 12000) begin step(); n++; end
    check({done, retry}, 2'b10);
    check({floaded, ploaded}, {fl, pr});
    check(mdl.ctrl_log, pres ? 16'ha0a1 : 16'h00a0);
    check(mdl.starts, pres ? 2 : 1);
    check({dev, cls}, {fb(b, 5), fb(b, 4), fb(b, 7), fb(b, 6)});
    check({ssv, ssid}, {fb(b, 9), fb(b, 8), fb(b, 11), fb(b, 10)});
    check(phy, {fb(b, 15), fb(b, 14), fb(b, 13), fb(b, 12)});
  endtask : run
  initial begin
    run(8'haa, 8'haa, 8'h55, 1'b0, 8'h55);
    run(8'haa, 8'h33, 8'h55, 1'b1, 8'h55);
    run(8'haa, 8'haa, 8'h44, 1'b1, 8'h00);
    run(8'h00, 8'haa, 8'h55, 1'b1, 8'h55);
    report_and_stop();
  end
endmodule : test_cal_loader
